/* rtl/spb_pkg.sv */
// Purpose: shared constants and types of the secondary bus interface
// Assumes: 32-bit multiplexed bus, one clock, active-low pins
// Notes:   pin values and pin enables travel as separate packed structs
package spb_pkg;
	// ==========================================================
	// commands and timing
	localparam logic [3:0] SPB_CMD_MEM_RD  = 4'h6;
	localparam logic [3:0] SPB_CMD_MEM_WR  = 4'h7;
	localparam int         SPB_CMD_WR_BIT  = 0;
	localparam logic [2:0] SPB_DEVSEL_CLKS = 3'h5;
	localparam logic [1:0] SPB_BUF_DEPTH   = 2'h2;

	// ==========================================================
	// pin carriers
	typedef struct packed {
		logic [31:0] ad;
		logic [3:0]  sec_cmd_byte_enable_lines;
		logic        sec_parity_line;
		logic        frame_n;
		logic        sec_initiator_ready_n;
		logic        sec_target_ready_n;
		logic        sec_device_select_n;
		logic        stop_n;
		logic        lock_n;
	} spb_pins_t;

	typedef struct packed {
		logic ad;
		logic cmd_be;
		logic parity;
		logic frame;
		logic init_rdy;
		logic tgt_rdy;
		logic dev_sel;
		logic stop;
		logic lock;
	} spb_oe_t;

	// reset: data lines driven low, control lines released and deasserted
	localparam spb_pins_t SPB_PINS_RST = {32'h0000_0000, 4'h0, 1'b0, 6'h3f};
	localparam spb_oe_t   SPB_OE_RST   = {3'h7, 6'h00};

	// ==========================================================
	// user-side carriers
	typedef struct packed {
		logic [31:0] addr;
		logic [3:0]  cmd;
		logic [3:0]  be;
		logic [7:0]  len;
		logic        lock;
	} spb_req_t;

	typedef struct packed {
		logic [31:0] data;
		logic [3:0]  be;
		logic        last;
	} spb_word_t;

	typedef enum logic [1:0] {SPB_OK, SPB_ABORT, SPB_STOPPED} spb_stat_t;

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_DATA, ST_END, ST_TURN, ST_T_CLAIM, ST_T_DATA, ST_T_TURN
	} spb_st_t;
endpackage : spb_pkg

/* rtl/spb_buf2.sv */
// Purpose: two-entry word buffer with valid/ready on both sides
// Assumes: fill and drain on the same clock
// Notes:   write ready comes from a flip-flop, so a full buffer refuses at once
`timescale 1ns/1ns
module spb_buf2
	import spb_pkg::*;
(
	input  wire logic      i_clk,
	input  wire logic      i_rst_n,
	input  wire logic      i_wr_valid,
	output wire logic      o_wr_ready,
	input  wire spb_word_t i_wr_word,
	output wire logic      o_rd_valid,
	input  wire logic      i_rd_ready,
	output wire spb_word_t o_rd_word
);
	// ==========================================================
	// state
	typedef struct packed {
		spb_word_t [1:0] mem;
		logic            wp;
		logic            rp;
		logic [1:0]      cnt;
		logic            ready;
	} spb_buf_t;

	localparam spb_buf_t BUF_RST = '{mem: '0, wp: 1'b0, rp: 1'b0, cnt: 2'h0, ready: 1'b1};

	spb_buf_t s;
	spb_buf_t next_s;
	logic     push;
	logic     pop;

	// ==========================================================
	// next state
	always_comb
	begin
		next_s = s;
		push   = i_wr_valid && s.ready;
		pop    = i_rd_ready && (s.cnt != 2'h0);
		if (push)
		begin
			next_s.mem[s.wp] = i_wr_word;
			next_s.wp        = ~s.wp;
		end
		if (pop)
			next_s.rp = ~s.rp;
		next_s.cnt   = s.cnt + {1'b0, push} - {1'b0, pop};
		next_s.ready = (next_s.cnt != SPB_BUF_DEPTH);
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			s <= BUF_RST;
		else
			s <= next_s;
	end

	assign o_wr_ready = s.ready;
	assign o_rd_valid = (s.cnt != 2'h0);
	assign o_rd_word  = s.mem[s.rp];
endmodule : spb_buf2

/* rtl/spb_sec_if.sv */
// Purpose: secondary-side bus engine of a two-port bridge, initiator and simple target
// Assumes: all bus pins are synchronous to I_MCLK, the secondary clock input
// Notes:   target claims single-word memory reads and writes and disconnects after one word
`timescale 1ns/1ns
// ==========================================================
// How it works
// RQ1 - a word moves only on an edge with both ready signals asserted
// RQ2 - address rides the data lines in the first frame cycle, data afterwards
// RQ3 - write data is sampled only while the initiator ready is asserted
// RQ4 - command goes out on the byte-enable lines in address phase, enables after
// RQ5 - idle bus with our grant: data, enable and parity lines are driven
// RQ6 - parity makes the ones over data, enables and parity even
// RQ7 - address parity follows the address phase by one clock
// RQ8 - read parity follows target ready by one clock, write parity follows initiator ready
// RQ9 - parity is released one clock after the data lines
// RQ10 - frame spans the access; its removal marks the last data phase
// RQ11 - every driven control line is driven high one clock before release
// RQ12 - once asserted in a phase, a ready signal holds until the phase ends
// RQ13 - as target the bridge asserts device select to claim
// RQ14 - no device select within five clocks of frame gives a master abort
// RQ15 - a stop from the target ends our transaction
// RQ16 - lock goes low one clock after the first address phase of a locked access
// RQ17 - a lock seen on this bus is never carried upstream
// RQ18 - under reset controls are released and data, enable, parity lines driven low
// RQ19 - everything runs on the secondary clock input
module spb_sec_if
	import spb_pkg::*;
(
	input  wire logic        I_MCLK,
	input  wire logic        I_RESETN,
	input  wire spb_pins_t   I_PCI,
	output wire spb_pins_t   O_PCI,
	output wire spb_oe_t     O_PCI_OE,
	input  wire logic        I_GNT_N,
	input  wire logic        I_REQ_VALID,
	input  wire spb_req_t    I_REQ,
	output wire logic        O_DONE,
	output wire spb_stat_t   O_STATUS,
	input  wire logic        I_WD_VALID,
	input  wire spb_word_t   I_WD,
	output wire logic        O_WD_READY,
	output wire logic        O_RD_VALID,
	output wire logic [31:0] O_RD_DATA,
	input  wire logic [31:0] I_TGT_BASE,
	input  wire logic [31:0] I_TGT_MASK,
	input  wire logic [31:0] I_TGT_RDATA,
	output wire logic        O_TW_VALID,
	output wire spb_word_t   O_TW
);
	// ==========================================================
	// state
	typedef struct packed {
		spb_st_t     st;
		spb_pins_t   pin;
		spb_oe_t     oe;
		spb_req_t    req;
		logic [2:0]  cnt;
		logic        dsel;
		logic        loaded;
		logic [7:0]  rem;
		logic        tgt_wr;
		logic        frame_d;
		logic        done;
		spb_stat_t   stat;
		logic        rd_valid;
		logic [31:0] rd_data;
		logic        tw_valid;
		spb_word_t   tw;
	} spb_state_t;

	localparam spb_state_t RST = '{st: ST_IDLE, pin: SPB_PINS_RST, oe: SPB_OE_RST, req: '0,
		cnt: 3'h0, dsel: 1'b0, loaded: 1'b0, rem: 8'h00, tgt_wr: 1'b0, frame_d: 1'b1,
		done: 1'b0, stat: SPB_OK, rd_valid: 1'b0, rd_data: 32'h0, tw_valid: 1'b0, tw: '0};

	spb_state_t s;
	spb_state_t next_s;
	logic       bus_idle;
	logic       tgt_start;
	logic       xfer;
	logic       wr;
	logic       fin;
	logic       pop;
	logic       buf_valid;
	spb_word_t  buf_word;

	// ==========================================================
	// write data buffer; a slow target fills it and stalls the user
	spb_buf2 u_buf (
		.i_clk      (I_MCLK),
		.i_rst_n    (I_RESETN),
		.i_wr_valid (I_WD_VALID),
		.o_wr_ready (O_WD_READY),
		.i_wr_word  (I_WD),
		.o_rd_valid (buf_valid),
		.i_rd_ready (pop),
		.o_rd_word  (buf_word)
	);

	// ==========================================================
	// next state
	always_comb
	begin
		next_s   = s;
		fin      = 1'b0;
		pop      = 1'b0;
		wr       = s.req.cmd[SPB_CMD_WR_BIT];
		bus_idle = I_PCI.frame_n && I_PCI.sec_initiator_ready_n;
		// RQ13 claim decode
		tgt_start = !I_PCI.frame_n && s.frame_d &&
			((I_PCI.ad & I_TGT_MASK) == I_TGT_BASE) &&
			((I_PCI.sec_cmd_byte_enable_lines == SPB_CMD_MEM_RD) ||
			 (I_PCI.sec_cmd_byte_enable_lines == SPB_CMD_MEM_WR));
		// RQ1 both ready at the edge
		xfer = s.oe.init_rdy && !s.pin.sec_initiator_ready_n && !I_PCI.sec_target_ready_n;
		next_s.done     = 1'b0;
		next_s.rd_valid = 1'b0;
		next_s.tw_valid = 1'b0;
		next_s.frame_d  = I_PCI.frame_n;
		// RQ6 RQ7 RQ8 even parity over last clock's lines
		// bus levels, not our pins: as target the enables come from the initiator
		next_s.pin.sec_parity_line = ^{I_PCI.ad, I_PCI.sec_cmd_byte_enable_lines};
		// RQ9 parity enable trails the data enable by one clock
		next_s.oe.parity = s.oe.ad;
		unique case (s.st)
			ST_IDLE:
			begin
				// RQ11 controls were driven high last clock, release them now
				next_s.oe.frame    = 1'b0;
				next_s.oe.init_rdy = 1'b0;
				next_s.oe.tgt_rdy  = 1'b0;
				next_s.oe.dev_sel  = 1'b0;
				next_s.oe.stop     = 1'b0;
				next_s.oe.lock     = 1'b0;
				// RQ5 park on our grant
				next_s.pin.ad                        = 32'h0;
				next_s.pin.sec_cmd_byte_enable_lines = 4'h0;
				next_s.oe.ad                         = !I_GNT_N && bus_idle;
				next_s.oe.cmd_be                     = !I_GNT_N && bus_idle;
				// RQ17 a foreign lock is ignored, nothing goes upstream
				if (tgt_start)
				begin
					next_s.st                      = ST_T_CLAIM;
					next_s.tgt_wr                  = I_PCI.sec_cmd_byte_enable_lines[SPB_CMD_WR_BIT];
					next_s.oe.ad                   = 1'b0;
					next_s.oe.cmd_be               = 1'b0;
					next_s.pin.sec_device_select_n = 1'b0;
					next_s.pin.sec_target_ready_n  = 1'b1;
					next_s.pin.stop_n              = 1'b1;
					next_s.oe.dev_sel              = 1'b1;
					next_s.oe.tgt_rdy              = 1'b1;
					next_s.oe.stop                 = 1'b1;
				end
				else if (I_REQ_VALID && !I_GNT_N && bus_idle)
				begin
					// RQ2 address phase
					next_s.st                            = ST_ADDR;
					next_s.req                           = I_REQ;
					next_s.stat                          = SPB_OK;
					next_s.pin.ad                        = I_REQ.addr;
					// RQ4 command during address phase
					next_s.pin.sec_cmd_byte_enable_lines = I_REQ.cmd;
					next_s.oe.ad                         = 1'b1;
					next_s.oe.cmd_be                     = 1'b1;
					next_s.pin.frame_n                   = 1'b0;
					next_s.pin.sec_initiator_ready_n     = 1'b1;
					next_s.oe.frame                      = 1'b1;
					next_s.oe.init_rdy                   = 1'b1;
				end
			end
			ST_ADDR:
			begin
				next_s.st     = ST_DATA;
				next_s.cnt    = 3'h1;
				next_s.dsel   = 1'b0;
				next_s.loaded = 1'b0;
				// RQ16 lock one clock after the address phase
				if (s.req.lock)
				begin
					next_s.pin.lock_n = 1'b0;
					next_s.oe.lock    = 1'b1;
				end
				if (!wr)
				begin
					// read: turn the data lines round, present enables, ready at once
					next_s.oe.ad                         = 1'b0;
					next_s.pin.sec_cmd_byte_enable_lines = s.req.be;
					next_s.pin.sec_initiator_ready_n     = 1'b0;
					next_s.rem                           = s.req.len;
					// RQ10 single word read ends the frame at once
					next_s.pin.frame_n                   = (s.req.len <= 8'h01);
				end
			end
			ST_DATA:
			begin
				next_s.dsel = s.dsel | ~I_PCI.sec_device_select_n;
				if (xfer)
				begin
					if (wr)
					begin
						next_s.loaded                    = 1'b0;
						next_s.pin.sec_initiator_ready_n = 1'b1;
					end
					else
					begin
						next_s.rd_valid = 1'b1;
						next_s.rd_data  = I_PCI.ad;
						next_s.rem      = s.rem - 8'h01;
						// RQ10 frame drops with the last phase
						if (s.rem == 8'h02)
							next_s.pin.frame_n = 1'b1;
					end
				end
				if (xfer && s.pin.frame_n)
					fin = 1'b1;
				// RQ15 target asked us to stop
				else if (!I_PCI.stop_n)
				begin
					next_s.st                        = ST_END;
					next_s.stat                      = SPB_STOPPED;
					next_s.pin.frame_n               = 1'b1;
					next_s.pin.sec_initiator_ready_n = 1'b0;
				end
				// RQ14 master abort on a silent target
				else if (I_PCI.sec_device_select_n && !s.dsel && (s.cnt == SPB_DEVSEL_CLKS))
				begin
					next_s.st                        = ST_END;
					next_s.stat                      = SPB_ABORT;
					next_s.pin.frame_n               = 1'b1;
					next_s.pin.sec_initiator_ready_n = 1'b0;
				end
				else
				begin
					if (!s.dsel)
						next_s.cnt = s.cnt + 3'h1;
					// RQ12 a new word is loaded only once the previous phase completed
					if (wr && !next_s.loaded && buf_valid)
					begin
						pop                                  = 1'b1;
						next_s.loaded                        = 1'b1;
						next_s.pin.ad                        = buf_word.data;
						// RQ4 byte enables during data phases
						next_s.pin.sec_cmd_byte_enable_lines = buf_word.be;
						next_s.pin.sec_initiator_ready_n     = 1'b0;
						next_s.pin.frame_n                   = buf_word.last;
					end
				end
			end
			ST_END:
			begin
				// last phase after stop or abort: hold ready until stop or target ready is low; with no device select seen, end at once
				if (!I_PCI.stop_n || !I_PCI.sec_target_ready_n || !s.dsel)
				begin
					fin = 1'b1;
					if (!wr && !I_PCI.sec_target_ready_n)
					begin
						next_s.rd_valid = 1'b1;
						next_s.rd_data  = I_PCI.ad;
					end
				end
			end
			ST_TURN:
				next_s.st = ST_IDLE;
			ST_T_CLAIM:
			begin
				// disconnect with data: one word per claim keeps the target simple
				next_s.st                     = ST_T_DATA;
				next_s.pin.sec_target_ready_n = 1'b0;
				next_s.pin.stop_n             = 1'b0;
				next_s.oe.ad                  = !s.tgt_wr;
				next_s.pin.ad                 = I_TGT_RDATA;
			end
			ST_T_DATA:
			begin
				if (!I_PCI.sec_initiator_ready_n || (I_PCI.frame_n && s.frame_d))
				begin
					// RQ3 write data taken while initiator ready is low
					if (s.tgt_wr && !I_PCI.sec_initiator_ready_n)
					begin
						next_s.tw_valid = 1'b1;
						next_s.tw       = {I_PCI.ad, I_PCI.sec_cmd_byte_enable_lines, 1'b1};
					end
					// RQ11 target controls driven high before release
					next_s.st                      = ST_T_TURN;
					next_s.oe.ad                   = 1'b0;
					next_s.pin.sec_device_select_n = 1'b1;
					next_s.pin.sec_target_ready_n  = 1'b1;
					next_s.pin.stop_n              = 1'b1;
				end
			end
			ST_T_TURN:
				next_s.st = ST_IDLE;
		endcase
		if (fin)
		begin
			// RQ11 drive our controls high for two clocks, through turn and the first idle clock, then idle releases them
			next_s.st                        = ST_TURN;
			next_s.done                      = 1'b1;
			next_s.oe.ad                     = 1'b0;
			next_s.oe.cmd_be                 = 1'b0;
			next_s.pin.frame_n               = 1'b1;
			next_s.pin.sec_initiator_ready_n = 1'b1;
			next_s.pin.lock_n                = 1'b1;
		end
	end

	// ==========================================================
	// RQ19 single clock domain
	// RQ18 reset drives data lines low and releases controls
	always_ff @(posedge I_MCLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
			s <= RST;
		else
			s <= next_s;
	end

	assign O_PCI      = s.pin;
	assign O_PCI_OE   = s.oe;
	assign O_DONE     = s.done;
	assign O_STATUS   = s.stat;
	assign O_RD_VALID = s.rd_valid;
	assign O_RD_DATA  = s.rd_data;
	assign O_TW_VALID = s.tw_valid;
	assign O_TW       = s.tw;

	// ==========================================================
	// checks
	default clocking cb @(posedge I_MCLK);
	endclocking
	default disable iff (!I_RESETN);

	sequence addr_seen;
		s.st == ST_ADDR;
	endsequence

	sequence devsel_silent;
		I_PCI.sec_device_select_n [*5];
	endsequence

	read_xfer_a : assert property (O_RD_VALID |-> $past(xfer)) // RQ1
		else $error("read word without both readies");
	addr_drive_a : assert property (addr_seen |-> !O_PCI.frame_n && O_PCI_OE.ad && O_PCI.ad == s.req.addr) // RQ2
		else $error("address phase lines wrong");
	read_be_a : assert property (addr_seen ##0 !s.req.cmd[SPB_CMD_WR_BIT] |=> // RQ4
		O_PCI.sec_cmd_byte_enable_lines == s.req.be && O_PCI_OE.cmd_be && !O_PCI_OE.ad)
		else $error("read enables not presented");
	park_drive_a : assert property (s.st == ST_IDLE && !I_GNT_N && bus_idle |=> O_PCI_OE.ad && O_PCI_OE.cmd_be) // RQ5
		else $error("bus not parked");
	parity_even_a : assert property ($past(O_PCI_OE.ad) |-> // RQ6
		^{O_PCI.sec_parity_line, $past(O_PCI.ad), $past(I_PCI.sec_cmd_byte_enable_lines)} == 1'b0)
		else $error("parity odd");
	par_release_a : assert property ($fell(O_PCI_OE.ad) |-> O_PCI_OE.parity ##1 !O_PCI_OE.parity) // RQ9
		else $error("parity release not one clock late");
	frame_release_a : assert property ($fell(O_PCI_OE.frame) |-> $past(O_PCI.frame_n) && $past(O_PCI_OE.frame, 2)) // RQ11
		else $error("frame released while low");
	devsel_release_a : assert property ($fell(O_PCI_OE.dev_sel) |-> $past(O_PCI.sec_device_select_n)) // RQ11
		else $error("device select released while low");
	irdy_hold_a : assert property (O_PCI_OE.init_rdy && !O_PCI.sec_initiator_ready_n && // RQ12
		I_PCI.sec_target_ready_n && I_PCI.stop_n && !I_PCI.sec_device_select_n |=> !O_PCI.sec_initiator_ready_n)
		else $error("initiator ready dropped mid phase");
	tgt_claim_a : assert property (s.st == ST_IDLE && tgt_start |=> // RQ13
		!O_PCI.sec_device_select_n && O_PCI_OE.dev_sel ##1 !O_PCI.sec_target_ready_n && !O_PCI.stop_n)
		else $error("claim sequence wrong");
	master_abort_a : assert property (addr_seen ##1 devsel_silent |=> s.st == ST_END && s.stat == SPB_ABORT) // RQ14
		else $error("no master abort after five clocks");
	stop_honour_a : assert property (s.st == ST_DATA && !I_PCI.stop_n |=> O_PCI.frame_n ##[0:8] s.st == ST_TURN) // RQ15
		else $error("stop not honoured");
	lock_timing_a : assert property (addr_seen ##0 s.req.lock |=> !O_PCI.lock_n && O_PCI_OE.lock) // RQ16
		else $error("lock not asserted after address");
endmodule : spb_sec_if

/* test/spb_agent.sv */
// Purpose: behavioural agent on the secondary bus, target for the bridge and initiator toward it
// Assumes: control lines pulled up; where both drive, the bridge wins in this wire model
// Notes:   released data lines flip every cycle so a stale value never passes
`timescale 1ns/1ns
module spb_agent
	import spb_pkg::*;
(
	input  wire logic        i_clk,
	input  wire spb_pins_t   i_br,
	input  wire spb_oe_t     i_br_oe,
	output wire spb_pins_t   o_bus,
	input  wire logic [1:0]  i_mode,
	input  wire logic [1:0]  i_dly,
	input  wire logic [31:0] i_rd_base
);
	spb_pins_t   av     = SPB_PINS_RST;
	spb_oe_t     aoe    = '0;
	logic [36:0] noise  = 37'h0a_5a5a_5a5a;
	logic [35:0] wq[$];
	logic [31:0] cap_addr;
	logic [3:0]  cap_cmd;
	logic        lk;
	logic        lk_due = 1'b0;
	logic        pf     = 1'b1;
	logic        rd;
	logic        xf;
	int          st     = 0;
	int          cnt;
	int          n;

	function automatic logic [42:0] spb_mask(input spb_oe_t o);
		return {{32{o.ad}}, {4{o.cmd_be}}, o.parity, o[5:0]};
	endfunction : spb_mask

	// ==========================================================
	// wire model
	assign o_bus = (i_br & spb_mask(i_br_oe)) | (av & spb_mask(aoe) & ~spb_mask(i_br_oe))
		| ({noise, 6'h3f} & ~spb_mask(i_br_oe) & ~spb_mask(aoe));

	// ==========================================================
	// target side
	always @(posedge i_clk)
	begin
		noise <= ~noise;
		pf <= o_bus.frame_n;
		// parity follows our data by one clock
		av.sec_parity_line <= ^{o_bus.ad, o_bus.sec_cmd_byte_enable_lines};
		aoe.parity <= aoe.ad;
		lk_due <= 1'b0;
		if (lk_due)
			lk <= o_bus.lock_n;
		if (st == 3)
		begin
			aoe.dev_sel <= 1'b0;
			aoe.tgt_rdy <= 1'b0;
			aoe.stop <= 1'b0;
			st = 0;
		end
		if (st == 2)
		begin
			// a word moves only with both readies low; ours holds until then
			xf = !o_bus.sec_initiator_ready_n && !o_bus.sec_target_ready_n;
			if (xf && !rd)
				wq.push_back({o_bus.ad, o_bus.sec_cmd_byte_enable_lines});
			if (xf)
				n++;
			av.ad <= i_rd_base + n;
			// ready follows the wait state; the release below overrides it
			av.sec_target_ready_n <= (i_mode == 2'h2);
			// frame high marks the last phase; drive high one clock before release
			if (o_bus.frame_n && (xf || i_mode == 2'h2))
			begin
				av.sec_device_select_n <= 1'b1;
				av.sec_target_ready_n <= 1'b1;
				av.stop_n <= 1'b1;
				aoe.ad <= 1'b0;
				st = 3;
			end
		end
		if (st == 0 && i_br_oe.frame && !o_bus.frame_n && pf)
		begin
			cap_addr <= o_bus.ad;
			cap_cmd <= o_bus.sec_cmd_byte_enable_lines;
			rd = !o_bus.sec_cmd_byte_enable_lines[SPB_CMD_WR_BIT];
			lk_due <= 1'b1;
			cnt = i_dly;
			st = (i_mode == 2'h1) ? 0 : 1;
		end
		if (st == 1 && cnt != 0)
			cnt--;
		else if (st == 1)
		begin
			// claim with one wait state, then ready, or stop without data
			av.sec_device_select_n <= 1'b0;
			av.sec_target_ready_n <= 1'b1;
			av.stop_n <= (i_mode != 2'h2);
			av.ad <= i_rd_base;
			aoe.ad <= rd;
			aoe.dev_sel <= 1'b1;
			aoe.tgt_rdy <= 1'b1;
			aoe.stop <= 1'b1;
			n = 0;
			st = 2;
		end
	end

	// ==========================================================
	// initiator side, one data phase
	task automatic initiate(input logic [31:0] a, input logic [3:0] c, input logic [35:0] dw,
		output logic [31:0] rdat, output logic hit);
		int k;
		hit = 1'b0;
		rdat = '0;
		@(posedge i_clk);
		// address and command in the first frame cycle
		av.ad <= a;
		av.sec_cmd_byte_enable_lines <= c;
		av.frame_n <= 1'b0;
		av.sec_initiator_ready_n <= 1'b1;
		aoe.ad <= 1'b1;
		aoe.cmd_be <= 1'b1;
		aoe.frame <= 1'b1;
		aoe.init_rdy <= 1'b1;
		@(posedge i_clk);
		// single last phase, write data held while ready is low
		av.frame_n <= 1'b1;
		av.sec_initiator_ready_n <= 1'b0;
		av.ad <= dw[35:4];
		av.sec_cmd_byte_enable_lines <= dw[3:0];
		aoe.ad <= c[SPB_CMD_WR_BIT];
		for (k = 0; k < 8; k++)
		begin
			@(posedge i_clk);
			hit = !o_bus.sec_target_ready_n;
			rdat = o_bus.ad;
			if (hit || !o_bus.stop_n || (k >= 5 && o_bus.sec_device_select_n))
				break;
		end
		// controls high for one clock before release
		av.sec_initiator_ready_n <= 1'b1;
		aoe.ad <= 1'b0;
		aoe.cmd_be <= 1'b0;
		@(posedge i_clk);
		aoe.frame <= 1'b0;
		aoe.init_rdy <= 1'b0;
	endtask : initiate
endmodule : spb_agent

/* test/test_secondary_pci_bus_interface.sv */
// Purpose: self-checking bench for the secondary bus engine
// Assumes: the agent model shares the bus; one clock at 100 MHz
// Notes:   drivers note results in queues; a watcher matches them as outputs appear
`timescale 1ns/1ns
module test_secondary_pci_bus_interface;
	import spb_pkg::*;
	logic        mclk      = 1'b0;
	logic        resetn;
	spb_pins_t   pci_in;
	spb_pins_t   pci_out;
	spb_oe_t     pci_oe;
	logic        gnt_n     = 1'b1;
	logic        req_valid = 1'b0;
	spb_req_t    req       = '0;
	logic        done;
	spb_stat_t   status;
	logic        wd_valid  = 1'b0;
	spb_word_t   wd        = '0;
	logic        wd_ready;
	logic        rd_valid;
	logic [31:0] rd_data;
	logic [31:0] tgt_rdata = 32'h0;
	logic        tw_valid;
	spb_word_t   tw;
	logic [1:0]  mode      = 2'h0;
	logic [1:0]  dly       = 2'h0;
	logic [31:0] rd_base   = 32'h0;
	spb_pins_t   p_bus;
	spb_pins_t   p_out;
	spb_oe_t     p_oe;
	logic        live      = 1'b0;
	int          n_fail    = 0;
	int          compares  = 0;
	int          seed      = 61;
	int          cyc       = 0;
	spb_stat_t   exp_st[$];
	logic [31:0] exp_rd[$];
	spb_word_t   exp_tw[$];

	spb_sec_if dut (.I_MCLK(mclk), .I_RESETN(resetn), .I_PCI(pci_in), .O_PCI(pci_out), .O_PCI_OE(pci_oe),
		.I_GNT_N(gnt_n), .I_REQ_VALID(req_valid), .I_REQ(req), .O_DONE(done), .O_STATUS(status),
		.I_WD_VALID(wd_valid), .I_WD(wd), .O_WD_READY(wd_ready), .O_RD_VALID(rd_valid), .O_RD_DATA(rd_data),
		.I_TGT_BASE(32'h8000_0000), .I_TGT_MASK(32'hffff_0000), .I_TGT_RDATA(tgt_rdata),
		.O_TW_VALID(tw_valid), .O_TW(tw));
	spb_agent agent (.i_clk(mclk), .i_br(pci_out), .i_br_oe(pci_oe), .o_bus(pci_in), .i_mode(mode),
		.i_dly(dly), .i_rd_base(rd_base));

	initial
		forever #5 mclk = ~mclk;

	// ==========================================================
	// comparison and close
	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic close_out;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out

	// ==========================================================
	// watchers
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_fail++;
			close_out;
		end
		if (done === 1'b1)
			check("status", exp_st.size() ? exp_st.pop_front() : {1'b1, 63'h0}, status);
		if (rd_valid === 1'b1)
			check("read word", exp_rd.size() ? exp_rd.pop_front() : {1'b1, 63'h0}, rd_data);
		if (tw_valid === 1'b1)
			check("target word", exp_tw.size() ? exp_tw.pop_front() : {1'b1, 63'h0}, tw);
		if (!resetn && cyc > 1)
		begin
			check("reset enables", SPB_OE_RST, pci_oe);
			check("reset lines", {37'h0, 2'b10}, {pci_out[42:6], wd_ready, done});
		end
		else if (live)
		begin
			check("parity enable", p_oe.ad, pci_oe.parity);
			if (pci_oe.parity)
				check("parity", ^{p_bus.ad, p_bus.sec_cmd_byte_enable_lines}, pci_out.sec_parity_line);
			for (int i = 0; i < 6; i++)
				if (p_oe[i] && !pci_oe[i])
					check("release level", 1, p_out[i]);
		end
		live <= resetn;
		p_bus <= pci_in;
		p_out <= pci_out;
		p_oe <= pci_oe;
	end

	// ==========================================================
	// drivers
	task automatic bus_req(input logic [31:0] a, input logic [3:0] c, input logic [7:0] len,
		input logic lk, input int lim);
		int k;
		req <= '{addr: a, cmd: c, be: 4'h0, len: len, lock: lk};
		req_valid <= 1'b1;
		for (k = 0; k < 200 && done !== 1'b1; k++)
			@(posedge mclk);
		req_valid <= 1'b0;
		check("cycles to done", 1, k <= lim);
		repeat (2) @(posedge mclk);
	endtask : bus_req

	task automatic rd_test(input logic [31:0] a, input logic [7:0] len, input logic [1:0] m, input logic lk);
		logic [31:0] b;
		b = $random(seed);
		rd_base <= b;
		mode <= m;
		dly <= 2'($random(seed));
		for (int i = 0; i < len && m == 2'h0; i++)
			exp_rd.push_back(b + i);
		exp_st.push_back(m == 2'h0 ? SPB_OK : m == 2'h1 ? SPB_ABORT : SPB_STOPPED);
		bus_req(a, SPB_CMD_MEM_RD, len, lk, m == 2'h1 ? 12 : 200);
		check("address", a, agent.cap_addr);
		check("command", SPB_CMD_MEM_RD, agent.cap_cmd);
		check("lock", !lk, agent.lk);
	endtask : rd_test

	task automatic tgt_test(input logic [31:0] a, input logic [3:0] c, input logic want);
		logic [31:0] d;
		logic [31:0] t;
		logic [31:0] r;
		logic [3:0]  be;
		logic        hit;
		d = $random(seed);
		t = $random(seed);
		be = 4'($random(seed));
		tgt_rdata <= t;
		if (want && c == SPB_CMD_MEM_WR)
			exp_tw.push_back('{data: d, be: be, last: 1'b1});
		agent.initiate(a, c, {d, be}, r, hit);
		check("claim", want, hit);
		if (want && c == SPB_CMD_MEM_RD)
			check("target read", t, r);
		repeat (2) @(posedge mclk);
	endtask : tgt_test

	// ==========================================================
	// main sequence
	initial
	begin
		spb_word_t w[2];
		resetn = 1'b0;
		repeat (8) @(posedge mclk);
		resetn <= 1'b1;
		gnt_n <= 1'b0;
		repeat (3) @(posedge mclk);
		check("park", 3'h7, {pci_oe.ad, pci_oe.cmd_be, pci_oe.parity});
		$display("test park finished");
		rd_test(32'h1000_0040, 8'h1, 2'h0, 1'b0);
		for (int i = 0; i < 6; i++)
			rd_test($random(seed) & 32'h7fff_fffc, 8'(1 + ($random(seed) & 3)), 2'h0, 1'($random(seed)));
		$display("test reads finished");
		for (int i = 0; i < 2; i++)
			w[i] = '{data: $random(seed), be: 4'($random(seed)), last: 1'(i)};
		mode <= 2'h0;
		wd_valid <= 1'b1;
		wd <= w[0];
		@(posedge mclk);
		wd <= w[1];
		@(posedge mclk);
		wd_valid <= 1'b0;
		@(posedge mclk);
		check("buffer full", 0, wd_ready);
		dly <= 2'h3;
		exp_st.push_back(SPB_OK);
		bus_req(32'h2000_0100, SPB_CMD_MEM_WR, 8'h0, 1'b0, 200);
		for (int i = 0; i < 2; i++)
			check("written word", {w[i].data, w[i].be}, agent.wq.size() ? agent.wq.pop_front() : 64'h0);
		check("buffer drained", 1, wd_ready);
		$display("test write finished");
		rd_test(32'h3000_0000, 8'h1, 2'h1, 1'b0);
		rd_test(32'h3000_0010, 8'h2, 2'h2, 1'b1);
		$display("test abort and stop finished");
		gnt_n <= 1'b1;
		repeat (3) @(posedge mclk);
		check("unpark", 3'h0, {pci_oe.ad, pci_oe.cmd_be, pci_oe.parity});
		tgt_test(32'h8000_0010, SPB_CMD_MEM_WR, 1'b1);
		tgt_test(32'h8000_0020, SPB_CMD_MEM_RD, 1'b1);
		tgt_test(32'h4000_0010, SPB_CMD_MEM_WR, 1'b0);
		tgt_test(32'h8000_0030, 4'h2, 1'b0);
		$display("test target finished");
		repeat (4) @(posedge mclk);
		close_out;
	end
endmodule : test_secondary_pci_bus_interface
